//--- rtl/flash_host.sv
// Wishbone-controlled host that drives an asynchronous parallel NOR flash
//
// The register offsets and the Wishbone slave port were left to the implementer.
`default_nettype none
module flash_host
  import flash_host_pkg::*;
#(
  parameter int T_WP_NS = 50, // Write strobe low time
  parameter int T_WPH_NS = 30, // Write strobe high time
  parameter int T_RP_NS = 500, // min_reset_width
  parameter int T_RH_NS = 50, // post_reset_read_delay
  parameter logic [LIN_W-1:0] UNL1_ADDR = 21'h000AAA,
  parameter logic [LIN_W-1:0] UNL2_ADDR = 21'h000555,
  parameter logic [DQ_W-1:0] UNL1_DATA = 16'h00AA,
  parameter logic [DQ_W-1:0] UNL2_DATA = 16'h0055,
  parameter logic [DQ_W-1:0] PROG_DATA = 16'h00A0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output flash_pins_s pins_o,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic [DQ_W-1:0] dq_oe_o,
  input wire logic ready_busy_out_i
);
  localparam logic [CNT_W-1:0] WP_CYC = CNT_W'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WPH_CYC = CNT_W'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RH_CYC = CNT_W'((T_RH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RDC = CNT_W'(RD_CYC);

  // Linear address to pins; byte bit leaves on the top data line
  function automatic logic [ADDR_W-1:0] pin_addr(input logic [LIN_W-1:0] lin,
                                                 input logic bmode);
    pin_addr = bmode ? lin[LIN_W-1:1] : lin[ADDR_W-1:0];
  endfunction : pin_addr

  // Address of a program sequence step
  function automatic logic [LIN_W-1:0] step_addr(input logic [1:0] st,
                                                 input logic [LIN_W-1:0] tgt);
    case (st)
      STEP_UNL1: step_addr = UNL1_ADDR;
      STEP_UNL2: step_addr = UNL2_ADDR;
      STEP_SETUP: step_addr = UNL1_ADDR;
      default: step_addr = tgt;
    endcase
  endfunction : step_addr

  // Data of a program sequence step
  function automatic logic [DQ_W-1:0] step_data(input logic [1:0] st,
                                                input logic [DQ_W-1:0] tgt);
    case (st)
      STEP_UNL1: step_data = UNL1_DATA;
      STEP_UNL2: step_data = UNL2_DATA;
      STEP_SETUP: step_data = PROG_DATA;
      default: step_data = tgt;
    endcase
  endfunction : step_data

  // Pin synchronisers, three stages each
  logic [DQ_W-1:0] dq_s1_reg, dq_s2_reg, dq_s3_reg, dq_reg; // Data input chain
  logic rb_s1_reg, rb_s2_reg, rb_s3_reg, rb_reg; // Ready/busy chain

  // Controller state
  host_state_e state_reg, state_next; // Pin sequencer
  logic [CNT_W-1:0] cnt_reg, cnt_next; // Timing countdown
  logic [1:0] step_reg, step_next; // Sequence step
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next; // Mode control
  logic [LIN_W-1:0] addr_reg, addr_next; // Target address
  logic [DQ_W-1:0] wdata_reg, wdata_next; // Write data
  logic [DQ_W-1:0] rdata_reg, rdata_next; // Last read data
  logic abort_reg, abort_next; // Reset hit a busy device
  flash_pins_s pins_reg, pins_next; // Registered pin levels
  logic [DQ_W-1:0] dqo_reg, dqo_next; // Data lines out
  logic [DQ_W-1:0] dqoe_reg, dqoe_next; // Data lines enable
  logic ack_reg, ack_next; // Bus acknowledge
  logic [31:0] dat_reg, dat_next; // Bus read data

  logic wb_req; // New bus access this cycle
  logic wb_wr; // New bus write
  logic bmode; // Byte mode in effect
  logic fast; // Two-cycle programming in effect
  logic [DQ_W-1:0] drive_lo; // Enables that put write data out
  logic [LIN_W-1:0] saddr; // Address of the step being launched
  logic [DQ_W-1:0] sdata; // Data of the step being launched

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  assign bmode = ctrl_reg[CTRL_BYTE];
  assign fast = ctrl_reg[CTRL_FAST] | ctrl_reg[CTRL_ACC];
  // Byte mode drives only the low lane with data; DQ14..DQ8 stay floated
  assign drive_lo = bmode ? {{(DQ_W-BYTE_W){1'b0}}, {BYTE_W{1'b1}}} : {DQ_W{1'b1}};

  // Input synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    dq_s1_reg <= dq_i;
    dq_s2_reg <= dq_s1_reg;
    dq_s3_reg <= dq_s2_reg;
    rb_s1_reg <= ready_busy_out_i;
    rb_s2_reg <= rb_s1_reg;
    rb_s3_reg <= rb_s2_reg;
    if (rst_i)
    begin
      dq_reg <= '0;
      rb_reg <= 1'b0;
    end
    else
    begin
      dq_reg <= (dq_s2_reg & dq_s3_reg) | (dq_reg & (dq_s2_reg ^ dq_s3_reg));
      if (rb_s2_reg == rb_s3_reg)
      begin
        rb_reg <= rb_s3_reg;
      end
    end
  end

  // Next-state logic for bus slave and pin sequencer
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    step_next = step_reg;
    ctrl_next = ctrl_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    abort_next = abort_reg;
    pins_next = pins_reg;
    dqo_next = dqo_reg;
    dqoe_next = dqoe_reg;
    ack_next = wb_req;
    dat_next = dat_reg;
    // Static pin levels follow control
    pins_next.byte_n = ~ctrl_reg[CTRL_BYTE];
    pins_next.protect_accel_pin = ctrl_reg[CTRL_PROT];
    pins_next.high_program_voltage = ctrl_reg[CTRL_ACC];
    saddr = '0;
    sdata = '0;
    // Byte mode: top line is the A-1 input, held as launched through a write
    dqo_next[DQ_W-1] = (bmode && state_reg != S_WR && state_reg != S_WREC) ?
                       addr_reg[0] : dqo_reg[DQ_W-1];
    dqoe_next[DQ_W-1] = bmode | dqoe_reg[DQ_W-1] & (state_reg == S_WR || state_reg == S_WREC);

    // Register reads
    if (wb_req & ~wb_we_i)
    begin
      case (wb_adr_i[4:2])
        REG_CTRL: dat_next = {{(32-CTRL_W){1'b0}}, ctrl_reg};
        REG_ADDR: dat_next = {{(32-LIN_W){1'b0}}, addr_reg};
        REG_DATA: dat_next = {{(32-DQ_W){1'b0}}, rdata_reg};
        REG_STATUS: dat_next = {28'h0, fast, abort_reg, rb_reg, state_reg != S_IDLE};
        default: dat_next = 32'h0; // Unmapped reads as zero
      endcase
    end

    case (state_reg)
      S_IDLE:
      begin
        // Deselected: device in standby with outputs floated
        pins_next.ce_n = 1'b1;
        pins_next.oe_n = 1'b1;
        pins_next.we_n = 1'b1;
        // Settings only change between cycles
        if (wb_wr && wb_adr_i[4:2] == REG_CTRL)
        begin
          ctrl_next = wb_dat_i[CTRL_W-1:0];
        end
        if (wb_wr && wb_adr_i[4:2] == REG_ADDR)
        begin
          addr_next = wb_dat_i[LIN_W-1:0];
        end
        if (wb_wr && wb_adr_i[4:2] == REG_DATA)
        begin
          wdata_next = wb_dat_i[DQ_W-1:0];
        end
        if (wb_wr && wb_adr_i[4:2] == REG_CMD)
        begin
          case (wb_dat_i[1:0])
            CMD_READ:
            begin
              // Plain array, status or ID read: select and enable low
              pins_next.addr = pin_addr(addr_reg, bmode);
              pins_next.ce_n = 1'b0;
              pins_next.oe_n = 1'b0;
              cnt_next = RDC;
              state_next = S_RD;
            end
            CMD_RESET:
            begin
              pins_next.reset_n = 1'b0;
              abort_next = ~rb_reg;
              cnt_next = RP_CYC;
              state_next = S_RST;
            end
            default:
            begin
              // Single write, or a full or fast program sequence
              step_next = (wb_dat_i[1:0] == CMD_WRITE) ? STEP_DATA :
                          (fast ? STEP_SETUP : STEP_UNL1);
              saddr = step_addr(step_next, addr_reg);
              sdata = step_data(step_next, wdata_reg);
              pins_next.addr = pin_addr(saddr, bmode);
              // Byte mode: A-1 follows each step's own address
              dqo_next = bmode ? {saddr[0], sdata[DQ_W-2:0]} : sdata;
              dqoe_next = drive_lo | {bmode, {(DQ_W-1){1'b0}}};
              pins_next.ce_n = 1'b0;
              pins_next.we_n = 1'b0;
              cnt_next = WP_CYC;
              state_next = S_WR;
            end
          endcase
        end
      end
      S_RD:
      begin
        if (cnt_reg == '0)
        begin
          // Only the low lane is valid in byte mode
          rdata_next = dq_reg & drive_lo;
          pins_next.ce_n = 1'b1;
          pins_next.oe_n = 1'b1;
          state_next = S_IDLE;
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      S_WR:
      begin
        if (cnt_reg == '0)
        begin
          // Rising strobe latches the command cycle
          pins_next.we_n = 1'b1;
          pins_next.ce_n = 1'b1;
          cnt_next = WPH_CYC;
          state_next = S_WREC;
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      S_WREC:
      begin
        if (cnt_reg != '0)
        begin
          cnt_next = cnt_reg - 1'b1;
        end
        else if (step_reg == STEP_DATA)
        begin
          // Data held through strobe-high time, then released
          dqoe_next = {bmode, {(DQ_W-1){1'b0}}};
          state_next = S_IDLE;
        end
        else
        begin
          step_next = step_reg + 1'b1;
          saddr = step_addr(step_next, addr_reg);
          sdata = step_data(step_next, wdata_reg);
          pins_next.addr = pin_addr(saddr, bmode);
          dqo_next = bmode ? {saddr[0], sdata[DQ_W-2:0]} : sdata;
          pins_next.ce_n = 1'b0;
          pins_next.we_n = 1'b0;
          cnt_next = WP_CYC;
          state_next = S_WR;
        end
      end
      S_RST:
      begin
        // Held low for the least reset width
        if (cnt_reg == '0)
        begin
          pins_next.reset_n = 1'b1;
          cnt_next = RH_CYC;
          state_next = S_RH;
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      S_RH:
      begin
        // No access before the post-reset delay
        if (cnt_reg == '0)
        begin
          state_next = S_RBW;
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      S_RBW:
      begin
        // Aborted program or erase holds busy low until internal reset ends
        if (rb_reg)
        begin
          state_next = S_IDLE;
        end
      end
      default:
      begin
        state_next = S_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= '0;
      step_reg <= STEP_UNL1;
      ctrl_reg <= CTRL_RST;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      abort_reg <= 1'b0;
      pins_reg <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
                    byte_n: 1'b1, protect_accel_pin: 1'b1, high_program_voltage: 1'b0};
      dqo_reg <= '0;
      dqoe_reg <= '0;
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      step_reg <= step_next;
      ctrl_reg <= ctrl_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      abort_reg <= abort_next;
      pins_reg <= pins_next;
      dqo_reg <= dqo_next;
      dqoe_reg <= dqoe_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign pins_o = pins_reg;
  assign dq_o = dqo_reg;
  assign dq_oe_o = dqoe_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
endmodule : flash_host
`default_nettype wire

//--- rtl/flash_host_pkg.sv
// Constants, types and register map for the parallel flash host controller
`default_nettype none
package flash_host_pkg;
  localparam int ADDR_W = 20; // Pin address A19..A0
  localparam int LIN_W = 21; // Linear address incl. byte bit
  localparam int DQ_W = 16; // Data lines
  localparam int BYTE_W = 8; // Lane used in byte mode
  localparam int CNT_W = 10; // Timing counter width
  // Register word offsets (byte address bits 4:2)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_CMD = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  // Control bits
  localparam int CTRL_BYTE = 0; // 1 = byte mode
  localparam int CTRL_PROT = 1; // Protect pin level, 0 guards boot sectors
  localparam int CTRL_ACC = 2; // Apply high program voltage
  localparam int CTRL_FAST = 3; // Use two-cycle programming
  localparam int CTRL_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h2; // Word mode, unprotected level
  // Status bits
  localparam int ST_BUSY = 0;
  localparam int ST_RB = 1;
  localparam int ST_ABORT = 2;
  localparam int ST_FAST = 3;
  // Commands written to REG_CMD
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_PROG = 2'h2;
  localparam logic [1:0] CMD_RESET = 2'h3;
  // Program sequence steps
  localparam logic [1:0] STEP_UNL1 = 2'h0;
  localparam logic [1:0] STEP_UNL2 = 2'h1;
  localparam logic [1:0] STEP_SETUP = 2'h2;
  localparam logic [1:0] STEP_DATA = 2'h3;
  // Timing
  localparam int CLK_NS = 10;
  localparam int ADDRESS_ACCESS_TIME_NS = 90; // address_access_time
  localparam int T_CE_NS = 90; // Select access time, covers standby exit
  localparam int SYNC_CYC = 4; // Three flops plus the agreement stage
  localparam int T_RD_NS = (ADDRESS_ACCESS_TIME_NS > T_CE_NS) ? ADDRESS_ACCESS_TIME_NS : T_CE_NS;
  localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RD = 3'b001,
    S_WR = 3'b010,
    S_WREC = 3'b011,
    S_RST = 3'b100,
    S_RH = 3'b101,
    S_RBW = 3'b110
  } host_state_e;

  // Flash control pins, all registered
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic byte_n;
    logic protect_accel_pin;
    logic high_program_voltage;
  } flash_pins_s;
endpackage : flash_host_pkg
`default_nettype wire

//--- tb/flash_dev_model.sv
// Behavioural parallel NOR flash device for the host bench
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int PROG_CYC = 300, // Program busy time
  parameter int RCV_CYC = 40, // Recovery after an aborted program
  parameter logic [7:0] ID_CODE = 8'h5C // Arbitrary identification value
) (
  input wire logic clk_i,
  input wire flash_pins_s pins_i,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic ready_busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DQ_W-1:0] mem [int]; // Sparse array, erased reads ones
  logic [LIN_W-1:0] la; // Latched command address with A-1
  logic [DQ_W-1:0] ld; // Latched command data
  logic [DQ_W-1:0] pd = 16'hFFFF; // Pending program pattern
  logic [ADDR_W-1:0] pa; // Pending program word
  logic [ADDR_W-1:0] aq; // Address seen last cycle
  logic [DQ_W-1:0] w;
  logic we_q = 1'b1;
  logic idm = 1'b0; // Identification mode
  int seq = 0;
  int busy = 0;
  int acc = 0;
  wire rd = !pins_i.ce_n && !pins_i.oe_n && pins_i.reset_n;
  wire fast = pins_i.high_program_voltage;
  initial ready_busy_o = 1'b1;
  initial dq_o = 16'h0000;
  // Device state, stepped on the bench clock
  always @(posedge clk_i)
  begin
    we_q <= pins_i.we_n;
    aq <= pins_i.addr;
    acc <= !rd ? 0 : (acc == 0 || pins_i.addr == aq) ? acc + 1 : 1;
    w = mem.exists(pins_i.addr) ? mem[pins_i.addr] : 16'hFFFF;
    if (!pins_i.we_n && !pins_i.ce_n)
    begin
      la <= {pins_i.addr, dq_i[15]};
      ld <= dq_i;
    end
    if (!pins_i.reset_n)
    begin
      seq <= 0;
      idm <= 1'b0;
      pd <= 16'hFFFF;
      if (busy > 0)
        busy <= RCV_CYC;
    end
    else if (busy > 0)
    begin
      busy <= busy - 1;
      if (busy == 1)
        mem[pa] = (mem.exists(pa) ? mem[pa] : 16'hFFFF) & pd;
    end
    else if (!we_q && pins_i.we_n)
      case (seq)
        0:
        begin
          seq <= (ld[7:0] == 8'hAA) ? 1 : (fast && ld[7:0] == 8'hA0) ? 3 : 0;
          if (ld[7:0] == 8'hF0)
            idm <= 1'b0;
        end
        1: seq <= (ld[7:0] == 8'h55) ? 2 : 0;
        2:
        begin
          seq <= (ld[7:0] == 8'hA0) ? 3 : (ld[7:0] == 8'h80) ? 4 : 0;
          if (ld[7:0] == 8'h90)
            idm <= 1'b1;
        end
        3:
        begin
          seq <= 0;
          pa <= la[LIN_W-1:1];
          pd <= pins_i.byte_n ? ld :
                la[0] ? {ld[7:0], 8'hFF} : {8'hFF, ld[7:0]};
          busy <= (!pins_i.protect_accel_pin && !fast && la[20:1] < 20'h02000) ?
                  0 : PROG_CYC;
        end
        4: seq <= (ld[7:0] == 8'hAA) ? 5 : 0;
        5: seq <= (ld[7:0] == 8'h55) ? 6 : 0;
        6:
        begin
          // Sector erase clears one 32-kword block; boot sub-blocks are lumped
          seq <= 0;
          if (ld[7:0] == 8'h10)
            mem.delete();
          if (ld[7:0] == 8'h30)
            for (int i = 0; i < 32768; i++)
              mem.delete({la[LIN_W-1:16], i[14:0]});
          if (ld[7:0] == 8'h10 || ld[7:0] == 8'h30)
          begin
            pd <= 16'hFFFF;
            busy <= PROG_CYC;
          end
        end
        default: seq <= 0;
      endcase
    ready_busy_o <= (busy == 0);
    // Data appears one access time after select and address settle
    if (rd && acc >= ADDRESS_ACCESS_TIME_NS / CLK_NS - 1)
    begin
      dq_o[7:0] <= busy > 0 ? {~pd[7], 7'h00} : idm ? ID_CODE :
                   (!pins_i.byte_n && dq_i[15]) ? w[15:8] : w[7:0];
      dq_o[15:8] <= (pins_i.byte_n && busy == 0 && !idm) ? w[15:8] : ~dq_o[15:8];
    end
    else
    begin
      // Released lines show a changing pattern, never the last value
      dq_o <= ~dq_o;
    end
  end
endmodule : flash_dev_model
`default_nettype wire

//--- tb/flash_host_sva.sv
// Port checker for the flash host controller
`default_nettype none
module flash_host_sva
  import flash_host_pkg::*;
#(
  parameter int T_WP_NS = 50, // Strobe low time
  parameter int T_RP_NS = 500 // Reset pulse time
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire flash_pins_s pins_o,
  input wire logic [DQ_W-1:0] dq_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WP_CYC = T_WP_NS / CLK_NS + 1; // Strobe low cycles
  localparam int RP_CYC = T_RP_NS / CLK_NS + 1; // Reset low cycles
  logic [CNT_W-1:0] lo_reg; // Strobe low count
  logic [CNT_W-1:0] lo_next;
  logic [CNT_W-1:0] rp_reg; // Reset low count
  logic [CNT_W-1:0] rp_next;
  // Low-time counters, cleared while the pin is high
  always_comb
  begin
    lo_next = pins_o.we_n ? '0 : lo_reg + 1'b1;
    rp_next = pins_o.reset_n ? '0 : rp_reg + 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    lo_reg <= rst_i ? '0 : lo_next;
    rp_reg <= rst_i ? '0 : rp_next;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked on next edge");
  a_read_no_drive: assert property (
    !pins_o.oe_n |-> !pins_o.ce_n && pins_o.we_n && dq_oe_o[7:0] == '0)
    else $error("read cycle with strobe low or lines driven");
  a_write_oe_high: assert property (
    !pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n && pins_o.reset_n)
    else $error("write cycle without select or with output enable");
  a_byte_lanes_float: assert property (
    !pins_o.byte_n |-> dq_oe_o[14:8] == '0 && dq_oe_o[15])
    else $error("byte mode lane use wrong");
  a_strobe_width: assert property ($rose(pins_o.we_n) |-> lo_reg == WP_CYC)
    else $error("write strobe width wrong");
  a_reset_width: assert property ($rose(pins_o.reset_n) |-> rp_reg == RP_CYC)
    else $error("reset pulse width wrong");
  a_post_reset_idle: assert property ($rose(pins_o.reset_n) |-> pins_o.ce_n [*6])
    else $error("access too soon after reset");
  a_access_addr_held: assert property (
    !pins_o.ce_n && !$past(pins_o.ce_n) |-> $stable(pins_o.addr))
    else $error("address moved during access");
  a_read_full_time: assert property ($fell(pins_o.oe_n) |->
    (!pins_o.oe_n && !pins_o.ce_n) [*7] ##1 (!pins_o.oe_n && !pins_o.ce_n) [*7] ##1 pins_o.oe_n)
    else $error("read cycle length wrong");
  cover property ($rose(pins_o.reset_n));
  cover property ($fell(pins_o.oe_n) && !pins_o.byte_n);
  cover property ($fell(pins_o.we_n) && pins_o.high_program_voltage);
endmodule : flash_host_sva
bind flash_host flash_host_sva #(.T_WP_NS(T_WP_NS), .T_RP_NS(T_RP_NS)) i_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pins_o(pins_o), .dq_oe_o(dq_oe_o));
`default_nettype wire

//--- tb/test_flash_host.sv
// Self-checking bench for the flash host controller
`default_nettype none
module test_flash_host;
  import flash_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0] sel = 4'hF;
  logic [31:0] rdat;
  logic [31:0] rv; // Last read word
  logic ack;
  logic rb;
  flash_pins_s pins;
  logic [DQ_W-1:0] h_dq, h_oe, m_dq, dq_wire;
  int n_fail = 0;
  int checks_done = 0;
  localparam logic [7:0] ID_CODE = 8'h5C; // Arbitrary identification value
  assign dq_wire = (h_dq & h_oe) | (m_dq & ~h_oe); // Shared data lines
  flash_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pins_o(pins), .dq_i(dq_wire), .dq_o(h_dq), .dq_oe_o(h_oe),
    .ready_busy_out_i(rb));
  flash_dev_model #(.ID_CODE(ID_CODE)) i_dev (.clk_i(clk_i), .pins_i(pins), .dq_i(dq_wire),
    .dq_o(m_dq), .ready_busy_o(rb));
  initial forever #5 clk_i = ~clk_i;
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  // One classic cycle, held until ack is sampled
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr
  task poll(input int b, input logic want);
    do bus(1'b0, 5'h10, 32'h0, 4'hF); while (rv[b] !== want);
  endtask : poll
  task prog(input logic [31:0] c, input logic [31:0] a, input logic [31:0] d);
    poll(ST_BUSY, 1'b0);
    wr(5'h00, c);
    wr(5'h04, a);
    wr(5'h08, d);
    wr(5'h0C, 32'h2);
  endtask : prog
  // Device busy then ready again
  task done_prog;
    poll(ST_RB, 1'b0);
    poll(ST_RB, 1'b1);
  endtask : done_prog
  task fetch(input logic [31:0] a);
    poll(ST_BUSY, 1'b0);
    wr(5'h04, a);
    wr(5'h0C, 32'h0);
    poll(ST_BUSY, 1'b0);
    bus(1'b0, 5'h08, 32'h0, 4'hF);
  endtask : fetch
  // Single command cycle on the flash through CMD 1
  task cmdw(input logic [31:0] a, input logic [31:0] d);
    poll(ST_BUSY, 1'b0);
    wr(5'h04, a);
    wr(5'h08, d);
    wr(5'h0C, 32'h1);
  endtask : cmdw
  task unlock;
    cmdw(32'h00AAA, 32'hAA);
    cmdw(32'h00555, 32'h55);
  endtask : unlock
  task test_done;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 5'h00, 32'h0, 4'hF);
    chk("ctrl reset", rv, 32'h2);
    bus(1'b0, 5'h14, 32'h0, 4'hF);
    chk("unmapped", rv, 32'h0);
    bus(1'b1, 5'h00, 32'h7, 4'hE);
    bus(1'b0, 5'h00, 32'h0, 4'hF);
    chk("ctrl sel low", rv, 32'h2);
    prog(32'h2, 32'h06000, 32'h1234);
    wr(5'h00, 32'h0);
    fetch(32'h06000);
    chk("status", {24'h0, rv[7:0]}, 32'h80);
    bus(1'b0, 5'h00, 32'h0, 4'hF);
    chk("ctrl busy write", rv, 32'h2);
    poll(ST_RB, 1'b1);
    fetch(32'h06000);
    chk("word prog", rv, 32'h1234);
    prog(32'h6, 32'h08000, 32'hABCD);
    bus(1'b0, 5'h10, 32'h0, 4'hF);
    chk("fast flag", {31'h0, rv[ST_FAST]}, 32'h1);
    done_prog;
    wr(5'h00, 32'h2);
    fetch(32'h08000);
    chk("fast prog", rv, 32'hABCD);
    unlock;
    cmdw(32'h00AAA, 32'h90);
    fetch(32'h00000);
    chk("id code", {24'h0, rv[7:0]}, {24'h0, ID_CODE});
    cmdw(32'h00000, 32'hF0);
    unlock;
    cmdw(32'h00AAA, 32'h80);
    unlock;
    cmdw(32'h08000, 32'h30);
    done_prog;
    fetch(32'h08000);
    chk("sector erased", rv, 32'hFFFF);
    fetch(32'h06000);
    chk("other sector kept", rv, 32'h1234);
    prog(32'hA, 32'h0A000, 32'h0F0F);
    fetch(32'h0A000);
    chk("two cycles no bypass", rv, 32'hFFFF);
    prog(32'h3, 32'h1C001, 32'h5A);
    done_prog;
    fetch(32'h1C001);
    chk("byte read", {24'h0, rv[7:0]}, 32'h5A);
    wr(5'h00, 32'h2);
    fetch(32'h0E000);
    chk("byte lane", rv, 32'h5AFF);
    prog(32'h0, 32'h00100, 32'h0);
    wr(5'h00, 32'h2);
    fetch(32'h00100);
    chk("protected", rv, 32'hFFFF);
    prog(32'h2, 32'h10000, 32'h4321);
    poll(ST_RB, 1'b0);
    wr(5'h0C, 32'h3);
    poll(ST_BUSY, 1'b0);
    chk("abort flag", {31'h0, rv[ST_ABORT]}, 32'h1);
    fetch(32'h10000);
    chk("aborted", rv, 32'hFFFF);
    wr(5'h0C, 32'h3);
    poll(ST_BUSY, 1'b0);
    chk("idle reset", {31'h0, rv[ST_ABORT]}, 32'h0);
    prog(32'h2, 32'h10000, 32'h4321);
    done_prog;
    fetch(32'h10000);
    chk("restart", rv, 32'h4321);
    test_done;
  end
  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    test_done;
  end
endmodule : test_flash_host
`default_nettype wire
